// ==== aop_defs.svh ====
// Purpose: constants of the converter output port
// Assumes: 200 MHz core clock
// Notes:   timing counts derive from printed nanosecond figures
`ifndef AOP_DEFS_SVH
`define AOP_DEFS_SVH

// ****************************************
// clock and timing
// ****************************************
`define AOP_CLK_MHZ       200
`define AOP_CYC_CEIL(ns)  ((((ns) * `AOP_CLK_MHZ) + 999) / 1000)
`define AOP_T_PER0_NS     25
`define AOP_T_PER1_NS     50
`define AOP_T_PER2_NS     100
`define AOP_T_PER3_NS     200
`define AOP_CNT_W         6
`define AOP_PER0_CYC      6'(`AOP_CYC_CEIL(`AOP_T_PER0_NS))
`define AOP_PER1_CYC      6'(`AOP_CYC_CEIL(`AOP_T_PER1_NS))
`define AOP_PER2_CYC      6'(`AOP_CYC_CEIL(`AOP_T_PER2_NS))
`define AOP_PER3_CYC      6'(`AOP_CYC_CEIL(`AOP_T_PER3_NS))

// ****************************************
// word and pin layout
// ****************************************
`define AOP_RES_W         16
`define AOP_BITS_LAST     4'hF
`define AOP_PIN_CLKSRC    4
`define AOP_PIN_SYNCPOL   5
`define AOP_PIN_RDTIME    7
`define AOP_PIN_SERIAL_RESULT_OUT     8
`define AOP_PIN_SCLK      9
`define AOP_PIN_SYNC      10
`define AOP_PIN_DIV_LO    2
`define AOP_PIN_DIV_HI    3

// ****************************************
// register port
// ****************************************
`define AOP_ADDR_CTRL     4'h0
`define AOP_ADDR_STATUS   4'h1
`define AOP_ADDR_RESULT   4'h2
`define AOP_CTRL_REPLAY   0

`endif

// ==== aop_pkg.sv ====
// Purpose: types of the converter output port
// Assumes: aop_defs.svh for widths
// Notes:   status register packs aop_modes_t in its low bits
package aop_pkg;

  typedef enum logic [1:0] {
    AOP_TX_IDLE  = 2'h0,
    AOP_TX_SHIFT = 2'h1,
    AOP_TX_DONE  = 2'h3
  } aop_tx_state_t;

  typedef struct packed {
    logic [1:0] divider;
    logic       byte_swap;
    logic       coding_binary;
    logic       master_rac;
    logic       read_during;
    logic       sync_act_low;
    logic       clk_ext;
    logic       serial;
  } aop_modes_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } aop_reg_req_t;

endpackage

// ==== aop_serial_tx.sv ====
// Purpose: serial shifter with internal clock divider or external clock
// Assumes: ext_sclk is synchronous to clk
// Notes:   data advance on internal falling or external rising edges
`timescale 1ns/100ps
`default_nettype none
`include "aop_defs.svh"

module aop_serial_tx (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  reset,
  // word to send
  input  wire logic                  start,
  input  wire logic [15:0]           word,
  // clocking choice
  input  wire logic                  clk_internal,
  input  wire logic [1:0]            divider,
  input  wire logic                  ext_sclk,
  // serial signals
  output logic                       sclk_out,
  output logic                       sd_out,
  output logic                       frame_act,
  output logic                       busy
);

  aop_pkg::aop_tx_state_t state;
  aop_pkg::aop_tx_state_t next_state;
  logic [15:0]            shreg;
  logic [3:0]             bits_left;
  logic [`AOP_CNT_W-1:0]  ph;
  logic [`AOP_CNT_W-1:0]  per_q;
  logic                   int_q;
  logic                   ext_q;

  // ****************************************
  // edge decode
  // ****************************************
  wire [`AOP_CNT_W-1:0] per_sel  = (divider == 2'h0) ? `AOP_PER0_CYC :
                                   (divider == 2'h1) ? `AOP_PER1_CYC :
                                   (divider == 2'h2) ? `AOP_PER2_CYC : `AOP_PER3_CYC;
  wire [`AOP_CNT_W-1:0] hi_cyc   = `AOP_CNT_W'((per_q + `AOP_CNT_W'(1)) >> 1);
  wire [`AOP_CNT_W-1:0] lo_cyc   = per_q - hi_cyc;
  wire                  shifting = (state == aop_pkg::AOP_TX_SHIFT);
  wire                  ext_rise = ext_sclk & ~ext_q;
  wire                  int_rise = int_q & ~sclk_out & (ph == lo_cyc - `AOP_CNT_W'(1));
  wire                  int_fall = int_q & sclk_out & (ph == hi_cyc - `AOP_CNT_W'(1));
  wire                  advance  = shifting & (int_q ? int_fall : ext_rise);
  wire                  last     = advance & (bits_left == 4'h0);
  wire                  take     = start & (state == aop_pkg::AOP_TX_IDLE);

  assign busy = (state != aop_pkg::AOP_TX_IDLE);

  always_comb begin
    unique case (state)
      aop_pkg::AOP_TX_IDLE:  next_state = take ? aop_pkg::AOP_TX_SHIFT : aop_pkg::AOP_TX_IDLE;
      aop_pkg::AOP_TX_SHIFT: next_state = last ? aop_pkg::AOP_TX_DONE : aop_pkg::AOP_TX_SHIFT;
      aop_pkg::AOP_TX_DONE:  next_state = aop_pkg::AOP_TX_IDLE;
      default:               next_state = aop_pkg::AOP_TX_IDLE;
    endcase
  end

  // ****************************************
  // shift register and clock phase
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      state     <= aop_pkg::AOP_TX_IDLE;
      shreg     <= 16'h0000;
      bits_left <= 4'h0;
      ph        <= `AOP_CNT_W'(0);
      per_q     <= `AOP_PER0_CYC;
      int_q     <= 1'b0;
      ext_q     <= 1'b0;
      sclk_out  <= 1'b0;
      sd_out    <= 1'b0;
      frame_act <= 1'b0;
    end else begin
      state     <= next_state;
      ext_q     <= ext_sclk;
      frame_act <= (next_state == aop_pkg::AOP_TX_SHIFT);
      if (take) begin
        sd_out    <= word[15];
        shreg     <= {word[14:0], 1'b0};
        bits_left <= `AOP_BITS_LAST;
        per_q     <= per_sel;
        int_q     <= clk_internal;
        ph        <= `AOP_CNT_W'(0);
        sclk_out  <= 1'b0;
      end else if (shifting) begin
        ph <= (int_rise | int_fall) ? `AOP_CNT_W'(0) : ph + `AOP_CNT_W'(1);
        if (int_rise) begin
          sclk_out <= 1'b1;
        end
        if (int_fall) begin
          sclk_out <= 1'b0;
        end
        if (advance && !last) begin
          sd_out    <= shreg[15];
          shreg     <= {shreg[14:0], 1'b0};
          bits_left <= bits_left - 4'h1;
        end
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [`AOP_CNT_W-1:0] since_rise;
  logic                  seen_rise;
  always_ff @(posedge clk) begin
    if (reset || take) begin
      since_rise <= `AOP_CNT_W'(0);
      seen_rise  <= 1'b0;
    end else if (int_rise) begin
      since_rise <= `AOP_CNT_W'(1);
      seen_rise  <= 1'b1;
    end else if (since_rise != {`AOP_CNT_W{1'b1}}) begin
      since_rise <= since_rise + `AOP_CNT_W'(1);
    end
  end

  sclk_period_min_a: assert property (@(posedge clk) disable iff (reset)
    int_rise && seen_rise |-> since_rise >= per_q)
    else $error("internal serial clock period below minimum");

  msb_first_a: assert property (@(posedge clk) disable iff (reset)
    take |=> sd_out == $past(word[15]) && shreg == {$past(word[14:0]), 1'b0})
    else $error("serial word does not start with msb");

  slow_divider_a: assert property (@(posedge clk) disable iff (reset)
    take && divider == 2'h3 |=> per_q == `AOP_PER3_CYC)
    else $error("divider 11 did not select slowest period");

  ext_hold_a: assert property (@(posedge clk) disable iff (reset)
    shifting && !int_q && !ext_rise |=> $stable(sd_out) && !sclk_out)
    else $error("data moved without an external clock edge");

endmodule // aop_serial_tx

`default_nettype wire

// ==== aop_output_port.sv ====
// Purpose: pin-configured parallel or serial result port of a 16-bit converter
// Assumes: select pins and pad inputs are synchronous to clk
// Notes:   pads are split into in, out and output enable
// Function
// - byte order select swaps result bytes on the parallel pads only
// - coding low inverts msb, twos complement
// - port type select picks parallel or serial
// - serial mode floats lines 0 and 1
// - parallel mode drives lines 2 and 3
// - master read after convert reads divider pins
// - other serial modes float and ignore them
// - line 4 selects internal or external clock
// - internal clock driven out, else follow host
// - line 5 sets frame sync polarity
// - divider sets 25/50/100/200 ns minimum period
// - serial result leaves msb first
`timescale 1ns/100ps
`default_nettype none
`include "aop_defs.svh"

module aop_output_port (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // static select pins
  input  wire logic                   byte_order_select,
  input  wire logic                   output_coding_select,
  input  wire logic                   port_type_select,
  // converter core
  input  wire logic [`AOP_RES_W-1:0]  conv_result,
  input  wire logic                   conv_done,
  // data bus pads
  input  wire logic [15:0]            pad_in,
  output logic      [15:0]            pad_out,
  output logic      [15:0]            pad_oe,
  // register port
  input  wire aop_pkg::aop_reg_req_t  reg_req,
  output logic      [15:0]            reg_rdata
);

  // ****************************************
  // mode decode
  // ****************************************
  aop_pkg::aop_modes_t modes;

  // shared pins only mean something once serial mode is chosen
  wire serial_sel      = port_type_select;
  wire clk_ext_pin     = pad_in[`AOP_PIN_CLKSRC];
  wire sync_pol_pin    = pad_in[`AOP_PIN_SYNCPOL];
  wire rd_timing_pin   = pad_in[`AOP_PIN_RDTIME];
  wire master_rac      = serial_sel & ~clk_ext_pin & ~rd_timing_pin;
  wire [1:0] div_pins  = {pad_in[`AOP_PIN_DIV_HI], pad_in[`AOP_PIN_DIV_LO]};
  wire [1:0] eff_div   = master_rac ? div_pins : 2'h0;

  assign modes.divider       = eff_div;
  assign modes.byte_swap     = byte_order_select;
  assign modes.coding_binary = output_coding_select;
  assign modes.master_rac    = master_rac;
  assign modes.read_during   = serial_sel & ~clk_ext_pin & rd_timing_pin;
  assign modes.sync_act_low  = serial_sel & sync_pol_pin;
  assign modes.clk_ext       = serial_sel & clk_ext_pin;
  assign modes.serial        = serial_sel;

  // ****************************************
  // result formatting
  // ****************************************
  wire        msb_fmt  = conv_result[15] ^ ~modes.coding_binary;
  wire [15:0] fmt_word = {msb_fmt, conv_result[14:0]};
  wire [15:0] par_word = modes.byte_swap ? {fmt_word[7:0], fmt_word[15:8]} : fmt_word;

  logic [15:0] par_data;
  logic [15:0] last_word;

  always_ff @(posedge clk) begin
    if (reset) begin
      par_data  <= 16'h0000;
      last_word <= 16'h0000;
    end else if (conv_done) begin
      par_data  <= par_word;
      last_word <= fmt_word;
    end
  end

  // ****************************************
  // register port
  // ****************************************
  wire ctrl_hit   = reg_req.wr & (reg_req.addr == `AOP_ADDR_CTRL);
  wire replay_req = ctrl_hit & reg_req.wdata[`AOP_CTRL_REPLAY];
  wire tx_busy;
  wire [15:0] status_word = {6'h00, tx_busy, modes};
  wire [15:0] next_rdata  = ~reg_req.rd                      ? 16'h0000 :
                            (reg_req.addr == `AOP_ADDR_STATUS) ? status_word :
                            (reg_req.addr == `AOP_ADDR_RESULT) ? last_word : 16'h0000;

  // data is valid only the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 16'h0000;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ****************************************
  // serial shifter
  // ****************************************
  // a result arriving while a word is still shifting is dropped, not queued
  wire        tx_start = modes.serial & ~tx_busy & (conv_done | replay_req);
  wire [15:0] tx_word  = conv_done ? fmt_word : last_word;
  wire        tx_sclk;
  wire        tx_sd;
  wire        tx_frame;

  aop_serial_tx u_tx (
    .clk          (clk),
    .reset        (reset),
    .start        (tx_start),
    .word         (tx_word),
    .clk_internal (~modes.clk_ext),
    .divider      (modes.divider),
    .ext_sclk     (pad_in[`AOP_PIN_SCLK]),
    .sclk_out     (tx_sclk),
    .sd_out       (tx_sd),
    .frame_act    (tx_frame),
    .busy         (tx_busy)
  );

  // ****************************************
  // pad mapping
  // ****************************************
  wire sync_level = tx_frame ^ modes.sync_act_low;
  wire sclk_drive = ~modes.clk_ext;
  wire sync_drive = ~modes.clk_ext;

  wire [15:0] ser_oe = (16'h0001 << `AOP_PIN_SERIAL_RESULT_OUT) |
                       ({15'h0000, sclk_drive} << `AOP_PIN_SCLK) |
                       ({15'h0000, sync_drive} << `AOP_PIN_SYNC);
  wire [15:0] ser_val = ({15'h0000, tx_sd} << `AOP_PIN_SERIAL_RESULT_OUT) |
                        ({15'h0000, tx_sclk} << `AOP_PIN_SCLK) |
                        ({15'h0000, sync_level} << `AOP_PIN_SYNC);

  // every line carries a result bit in parallel mode; serial owns three with the internal clock, only the data line with an external clock
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_pad
      assign pad_out[gi] = modes.serial ? ser_val[gi] : par_data[gi];
      assign pad_oe[gi]  = modes.serial ? ser_oe[gi] : 1'b1;
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  byte_order_low_a: assert property (@(posedge clk) disable iff (reset)
    conv_done && !byte_order_select && !port_type_select ##1 !port_type_select
    |-> pad_out == $past(fmt_word))
    else $error("straight byte order not on pads");

  byte_order_swap_a: assert property (@(posedge clk) disable iff (reset)
    conv_done && byte_order_select && !port_type_select ##1 !port_type_select
    |-> pad_out[7:0] == $past(fmt_word[15:8]) && pad_out[15:8] == $past(fmt_word[7:0]))
    else $error("swapped byte order not on pads");

  coding_msb_a: assert property (@(posedge clk) disable iff (reset)
    conv_done |=> last_word[15] == ($past(conv_result[15]) ^ ~$past(output_coding_select))
                  && last_word[14:0] == $past(conv_result[14:0]))
    else $error("output coding of msb wrong");

  parallel_drive_a: assert property (@(posedge clk) disable iff (reset)
    !port_type_select |-> pad_oe == 16'hFFFF && pad_out[3:2] == par_data[3:2])
    else $error("parallel mode does not drive all lines");

  serial_float_a: assert property (@(posedge clk) disable iff (reset)
    port_type_select |-> pad_oe[1:0] == 2'h0 && pad_oe[`AOP_PIN_SERIAL_RESULT_OUT])
    else $error("serial mode drives lines 0 and 1");

  divider_gate_a: assert property (@(posedge clk) disable iff (reset)
    port_type_select && (clk_ext_pin || rd_timing_pin)
    |-> modes.divider == 2'h0 && pad_oe[3:2] == 2'h0)
    else $error("divider pins used outside master read after convert");

  clock_source_a: assert property (@(posedge clk) disable iff (reset)
    port_type_select |-> pad_oe[`AOP_PIN_SCLK] == ~pad_in[`AOP_PIN_CLKSRC]
                         && !pad_oe[`AOP_PIN_CLKSRC])
    else $error("serial clock direction does not follow line 4");

  sync_idle_level_a: assert property (@(posedge clk) disable iff (reset)
    port_type_select && !clk_ext_pin && !tx_busy && !tx_start ##1 port_type_select && !clk_ext_pin
    |-> pad_out[`AOP_PIN_SYNC] == pad_in[`AOP_PIN_SYNCPOL])
    else $error("idle frame sync level wrong for polarity");

  result_shift_a: assert property (@(posedge clk) disable iff (reset)
    conv_done && port_type_select && !tx_busy
    |=> pad_out[`AOP_PIN_SERIAL_RESULT_OUT] == $past(msb_fmt) && tx_busy)
    else $error("serial transfer did not begin with msb");

endmodule // aop_output_port

`default_nettype wire

// ==== aop_host_model.sv ====
// Purpose: host side of the converter result port
// Assumes: host settings change only between transfers
// Notes:   captures internal-clock frames, tracks shortest clock period
`timescale 1ns/100ps
`default_nettype none

module aop_host_model (
  // clock
  input  wire logic        clk,
  // device pads
  input  wire logic [15:0] pad_out,
  input  wire logic [15:0] pad_oe,
  output logic      [15:0] pad_in,
  // host settings
  input  wire logic        ser,
  input  wire logic        clk_ext,
  input  wire logic        sync_low,
  input  wire logic        rd_during,
  input  wire logic        ext_sclk,
  input  wire logic [1:0]  div,
  // captured frame
  output logic      [15:0] word,
  output logic      [4:0]  n_bits,
  output logic      [5:0]  min_per
);
  logic        pat       = 1'b0;
  logic        prev_sclk = 1'b0;
  logic [5:0]  since     = 6'h00;
  logic        prev_frame = 1'b0;
  logic [15:0] h_val;
  logic [15:0] h_oe;
  wire         frame     = pad_out[10] ^ sync_low;

  // host drives select pins only in serial mode
  assign h_val = {6'h00, ext_sclk, 1'b0, rd_during, 1'b0, sync_low, clk_ext, div, 2'h0};
  assign h_oe  = ser ? {6'h00, clk_ext, 1'b0, 1'b1, 1'b0, 4'hF, 2'h0} : 16'h0000;
  // floating lines toggle so a stale level never reads as valid
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & h_oe & h_val) | (~pad_oe & ~h_oe & {16{pat}});

  always_ff @(posedge clk) begin
    pat       <= ~pat;
    prev_sclk <= pad_out[9];
    since     <= since + 6'h01;
    prev_frame <= frame;
    // results stay readable after the frame ends; clear only as a new frame opens
    if (frame && !prev_frame) begin
      n_bits  <= 5'h00;
      min_per <= 6'h3F;
    end else if (frame && pad_out[9] && !prev_sclk && !clk_ext) begin
      word   <= {word[14:0], pad_out[8]};
      n_bits <= n_bits + 5'h01;
      since  <= 6'h01;
      if (n_bits != 5'h00 && since < min_per) begin
        min_per <= since;
      end
    end
  end
endmodule // aop_host_model

`default_nettype wire

// ==== aop_output_port_tb.sv ====
// Purpose: self-checking bench of the converter result port
// Assumes: 200 MHz clock, synchronous active-high reset
// Notes:   host model drives serial select pins and captures frames
`timescale 1ns/100ps
`default_nettype none

module aop_output_port_tb;
  logic                  clk = 1'b0;
  logic                  reset;
  logic                  bos;
  logic                  ocs;
  logic                  pts;
  logic [15:0]           conv_result;
  logic                  conv_done;
  logic [15:0]           pad_in;
  logic [15:0]           pad_out;
  logic [15:0]           pad_oe;
  aop_pkg::aop_reg_req_t reg_req;
  logic [15:0]           reg_rdata;
  logic                  h_ext;
  logic                  h_sl;
  logic                  h_rdc;
  logic                  h_sclk;
  logic [1:0]            h_div;
  logic [15:0]           w_word;
  logic [4:0]            w_n;
  logic [5:0]            w_min;
  int                    n_fail = 0;
  int                    checks = 0;

  always #2.5 clk = ~clk;

  aop_output_port dut (.clk(clk), .reset(reset), .byte_order_select(bos),
    .output_coding_select(ocs), .port_type_select(pts), .conv_result(conv_result),
    .conv_done(conv_done), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .reg_req(reg_req), .reg_rdata(reg_rdata));

  aop_host_model host (.clk(clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in),
    .ser(pts), .clk_ext(h_ext), .sync_low(h_sl), .rd_during(h_rdc), .ext_sclk(h_sclk),
    .div(h_div), .word(w_word), .n_bits(w_n), .min_per(w_min));

  // ****************************************
  // shared tasks
  // ****************************************
  function automatic logic [15:0] fmt(input logic [15:0] raw, input logic cod);
    return {raw[15] ^ ~cod, raw[14:0]};
  endfunction

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic pulse(input logic [15:0] raw);
    @(posedge clk);
    conv_result <= raw;
    conv_done   <= 1'b1;
    @(posedge clk);
    conv_done   <= 1'b0;
    #1;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_req <= '{1'b0, 1'b1, a, 16'h0000};
    @(posedge clk);
    reg_req <= '0;
    #1 d = reg_rdata;
  endtask

  task automatic wait_frame();
    // let the host see the new frame open before trusting its bit count
    repeat (2) @(posedge clk);
    for (int k = 0; k < 2000 && w_n !== 5'h10; k++) @(posedge clk);
    repeat (60) @(posedge clk);
    #1;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_parallel();
    logic [15:0] e;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      bos <= i[0];
      ocs <= i[1];
      pulse(16'h8_3C5 + 16'h1_111 * i[15:0]);
      e = fmt(16'h8_3C5 + 16'h1_111 * i[15:0], i[1]);
      if (i[0]) e = {e[7:0], e[15:8]};
      chk("parallel word", e, pad_out);
      chk("parallel enables", 16'hFFFF, pad_oe);
    end
    $display("test parallel done");
  endtask

  task automatic ser_run(input logic [1:0] div, input logic rdc, input logic [5:0] per);
    logic [15:0] st;
    logic [1:0]  eff;
    @(posedge clk);
    pts   <= 1'b1;
    h_ext <= 1'b0;
    h_sl  <= div[0];
    h_div <= div;
    h_rdc <= rdc;
    repeat (4) @(posedge clk);
    pulse(16'h1_234 + {14'h0000, div});
    chk("frame sync on", {15'h0000, ~div[0]}, {15'h0000, pad_out[10]});
    chk("serial enables", 16'h0700, {5'h00, pad_oe[10:0]});
    wait_frame();
    chk("serial word", fmt(16'h1_234 + {14'h0000, div}, ocs), w_word);
    chk("clock period", {10'h000, per}, {10'h000, w_min});
    chk("frame sync idle", {15'h0000, div[0]}, {15'h0000, pad_out[10]});
    eff = rdc ? 2'h0 : div;
    reg_rd(4'h1, st);
    chk("status", {6'h00, 1'b0, eff, bos, ocs, ~rdc, rdc, div[0], 1'b0, 1'b1}, st);
    $display("test serial internal done");
  endtask

  task automatic test_external();
    logic [15:0] got;
    logic [15:0] d;
    @(posedge clk);
    h_ext  <= 1'b1;
    h_sclk <= 1'b0;
    repeat (4) @(posedge clk);
    pulse(16'hA_5F0);
    chk("ext enables", 16'h0100, {5'h00, pad_oe[10:0]});
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      #1 got = {got[14:0], pad_out[8]};
      @(posedge clk);
      h_sclk <= 1'b1;
      repeat (3) @(posedge clk);
      h_sclk <= 1'b0;
    end
    repeat (10) @(posedge clk);
    chk("ext word", fmt(16'hA_5F0, ocs), got);
    // replay the stored word on the internal clock
    h_ext   <= 1'b0;
    repeat (4) @(posedge clk);
    reg_req <= '{1'b1, 1'b0, 4'h0, 16'h0001};
    @(posedge clk);
    reg_req <= '0;
    wait_frame();
    chk("replay word", fmt(16'hA_5F0, ocs), w_word);
    reg_rd(4'h2, d);
    chk("result reg", fmt(16'hA_5F0, ocs), d);
    reg_rd(4'h3, d);
    chk("unmapped reg", 16'h0000, d);
    $display("test serial external done");
  endtask

  task automatic give_verdict();
    $display("checks %0d failures %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    {bos, ocs, pts, conv_done, h_ext, h_sl, h_rdc, h_sclk} = 8'h00;
    conv_result = 16'h0000;
    h_div       = 2'h0;
    reg_req     = '0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    test_parallel();
    for (int i = 0; i < 4; i++) ser_run(i[1:0], 1'b0, 6'h05 << i);
    ser_run(2'h3, 1'b1, 6'h05);
    test_external();
    give_verdict();
  end

  initial begin
    #200000;
    n_fail++;
    $display("Error watchdog expected done seen timeout");
    give_verdict();
  end
endmodule // aop_output_port_tb

`default_nettype wire
